//--- udp_adapter_pkg.sv
package udp_adapter_pkg;
	// ====================================================================
	// Protocol constants
	localparam logic [15:0] WELL_KNOWN_PORT = 16'h1049;
	localparam logic [15:0] SRC_PORT_BASE = 16'hC000;
	localparam int IP_W = 32;
	localparam int CHAR_W = 8;
	localparam int LEN_W = 16;
	localparam int CONN_W = 8;
	localparam int SEL_W = 2;
	localparam int MAX_PAYLOAD = 512;
	localparam int RXBUF_DEPTH = 1024;

	// ====================================================================
	// Request status codes
	localparam logic [1:0] ST_GOOD = 2'h0;
	localparam logic [1:0] ST_PORT_IN_USE = 2'h1;
	localparam logic [1:0] ST_NOT_OPEN = 2'h2;

	// ====================================================================
	// Request opcodes
	typedef enum logic [2:0] {
		OP_CONNECT = 3'b000,
		OP_LISTEN = 3'b001,
		OP_SEND = 3'b010,
		OP_RECEIVE = 3'b011,
		OP_CLOSE = 3'b100
	} op_t;

	// ====================================================================
	// Reset indication handling
	localparam logic RESET_AS_LOGOUT = 1'b0;
	localparam logic RESET_AS_HARD = 1'b1;
endpackage

//--- dgram_if.sv
`timescale 1ns/1ps
interface dgram_if;
	import udp_adapter_pkg::*;
	logic valid;
	logic ready;
	logic [CHAR_W-1:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface

//--- tx_framer.sv
`timescale 1ns/1ps
module tx_framer
	import udp_adapter_pkg::*;
#(
	parameter int PAYLOAD = MAX_PAYLOAD
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Character stream from the adapter
	dgram_if.snk chars,
	// Datagram fields
	input wire logic [IP_W-1:0] dstIp,
	input wire logic [15:0] srcPort,
	// Network side
	output logic txValid,
	output logic [CHAR_W-1:0] txData,
	output logic txStart,
	output logic txEnd,
	output logic [IP_W-1:0] txDstIp,
	output logic [15:0] txSrcPort,
	output logic [15:0] txDstPort,
	input wire logic txReady
);
	initial begin
		if (PAYLOAD < 1 || PAYLOAD > 65507)
			$error("PAYLOAD out of range");
	end

	logic [LEN_W-1:0] count;
	logic inDgram;

	// ====================================================================
	// Splitting into datagrams
	assign chars.ready = txReady || !txValid;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txValid <= 1'b0;
			txData <= '0;
			txStart <= 1'b0;
			txEnd <= 1'b0;
			count <= '0;
			inDgram <= 1'b0;
			txDstIp <= '0;
			txSrcPort <= '0;
			txDstPort <= '0;
		end else if (chars.ready) begin
			txValid <= chars.valid;
			if (chars.valid) begin
				txData <= chars.data;
				txStart <= !inDgram;
				txDstIp <= dstIp; // RULE9
				txSrcPort <= srcPort;
				txDstPort <= WELL_KNOWN_PORT; // RULE9
				if (chars.last || count == LEN_W'(PAYLOAD - 1)) begin // RULE8
					txEnd <= 1'b1;
					inDgram <= 1'b0;
					count <= '0;
				end else begin
					txEnd <= 1'b0;
					inDgram <= 1'b1;
					count <= count + 1'b1;
				end
			end
		end
	end
endmodule

//--- rx_buffer.sv
`timescale 1ns/1ps
module rx_buffer
	import udp_adapter_pkg::*;
#(
	parameter int DEPTH = RXBUF_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	// Fill and drain
	dgram_if.snk fill,
	dgram_if.src drain,
	output logic isEmpty
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("DEPTH must be a power of two");
	end

	logic [CHAR_W-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;

	// ====================================================================
	// Character store
	assign isEmpty = wp == rp;
	assign fill.ready = (wp - rp) != (AW+1)'(DEPTH);
	assign drain.valid = !isEmpty;
	assign drain.data = mem[rp[AW-1:0]];
	assign drain.last = (wp - rp) == (AW+1)'(1);

	always_ff @(posedge clk) begin
		if (fill.valid && fill.ready)
			mem[wp[AW-1:0]] <= fill.data;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp <= '0;
			rp <= '0;
		end else if (flush) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (fill.valid && fill.ready)
				wp <= wp + 1'b1;
			if (drain.valid && drain.ready)
				rp <= rp + 1'b1;
		end
	end
endmodule

//--- udp_link_service_adapter.sv
`timescale 1ns/1ps
// Contract
// RULE1: Connect establishes at once, allocates source port.
// RULE2: Connect or listen sends nothing on link.
// RULE3: Connected may precede request completion.
// RULE4: Second connect or listen refused, port busy.
// RULE5: Connect remote argument gives destination IP.
// RULE6: Local port argument selects interconnect port.
// RULE7: After listen, accept datagrams to port 4169.
// RULE8: Send split into one or more datagrams.
// RULE9: Datagrams carry port 4169 and remote IP.
// RULE10: Requester gives encoded length including escapes.
// RULE11: Never deliver more than receive maximum count.
// RULE12: Received indications report characters placed.
// RULE13: After close, still transmit accepted send data.
// RULE14: After close, incoming characters may be dropped.
// RULE15: After close, keep serving receives until drained.
// RULE16: Closed only after all received data delivered.
// RULE17: Reset indication acts as logout or hard reset.
// RULE18: Connection id made, returned on every indication.
module udp_link_service_adapter
	import udp_adapter_pkg::*;
#(
	parameter int PAYLOAD = MAX_PAYLOAD,
	parameter int DEPTH = RXBUF_DEPTH,
	parameter logic RESET_MODE = RESET_AS_LOGOUT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Service requests
	input wire logic reqValid,
	input wire op_t reqOp,
	input wire logic [SEL_W-1:0] reqLocalPort,
	input wire logic [IP_W-1:0] reqRemoteIp,
	input wire logic [LEN_W-1:0] reqLength,
	output logic reqDone,
	output logic [1:0] reqStatus,
	output logic [CONN_W-1:0] reqConn,
	// Send buffer characters
	input wire logic sendValid,
	input wire logic [CHAR_W-1:0] sendData,
	output logic sendReady,
	// Receive buffer characters
	output logic rcvValid,
	output logic [CHAR_W-1:0] rcvData,
	// Indications
	output logic connectedInd,
	output logic receivedInd,
	output logic [LEN_W-1:0] receivedCount,
	output logic closedInd,
	output logic [CONN_W-1:0] indConn,
	input wire logic resetInd,
	output logic hardResetReq,
	// Network transmit
	output logic txValid,
	output logic [CHAR_W-1:0] txData,
	output logic txStart,
	output logic txEnd,
	output logic [IP_W-1:0] txDstIp,
	output logic [15:0] txSrcPort,
	output logic [15:0] txDstPort,
	output logic [SEL_W-1:0] txPortSel,
	input wire logic txReady,
	// Network receive
	input wire logic rxValid,
	input wire logic [CHAR_W-1:0] rxData,
	input wire logic rxStart,
	input wire logic [15:0] rxDstPort,
	input wire logic [SEL_W-1:0] rxPortSel
);
	initial begin
		if (PAYLOAD < 1 || DEPTH < 2)
			$error("bad parameters");
	end

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_OPEN = 2'b01,
		S_CLOSING = 2'b10
	} conn_t;

	conn_t state;
	logic [CONN_W-1:0] connId;
	logic [IP_W-1:0] remoteIp;
	logic [SEL_W-1:0] portSel;
	logic [15:0] srcPort;
	logic [LEN_W-1:0] sendLeft;
	logic [LEN_W-1:0] next_sendLeft;
	logic [LEN_W-1:0] rcvLeft;
	logic [LEN_W-1:0] rcvPlaced;
	logic rcvActive;
	logic dgramOk;
	logic rxEmpty;
	logic openReq;
	logic logout;

	dgram_if txChars ();
	dgram_if rxFill ();
	dgram_if rxDrain ();

	function automatic logic is_open_req(input op_t op);
		return op == OP_CONNECT || op == OP_LISTEN;
	endfunction

	assign openReq = reqValid && is_open_req(reqOp);
	assign logout = resetInd && RESET_MODE == RESET_AS_LOGOUT; // RULE17

	// ====================================================================
	// Connection state
	// A connect or listen only changes state here; the framer sees no
	// characters, so nothing reaches the link.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			connId <= '0;
			remoteIp <= '0;
			portSel <= '0;
			srcPort <= '0;
		end else if (logout) begin
			state <= S_IDLE; // RULE17
		end else if (openReq && state == S_IDLE) begin
			state <= S_OPEN; // RULE1 RULE2
			connId <= connId + 1'b1; // RULE18
			portSel <= reqLocalPort; // RULE6
			srcPort <= SRC_PORT_BASE | 16'(CONN_W'(connId + 1'b1)); // RULE1
			if (reqOp == OP_CONNECT)
				remoteIp <= reqRemoteIp; // RULE5
		end else if (reqValid && reqOp == OP_CLOSE && state == S_OPEN) begin
			state <= S_CLOSING;
		end else if (state == S_CLOSING && rxEmpty && !rcvActive &&
				sendLeft == '0 && !txValid) begin
			state <= S_IDLE; // RULE13 RULE16
		end
	end

	// ====================================================================
	// Request completion and indications
	// Connected is raised in the same cycle as the completion.
	// The id stands on indConn at all times, so a received or closed
	// pulse carries the right id in its own cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reqDone <= 1'b0;
			reqStatus <= ST_GOOD;
			reqConn <= '0;
			connectedInd <= 1'b0;
			closedInd <= 1'b0;
			indConn <= '0;
			hardResetReq <= 1'b0;
		end else begin
			reqDone <= reqValid;
			reqConn <= connId;
			connectedInd <= 1'b0;
			closedInd <= 1'b0;
			hardResetReq <= resetInd && RESET_MODE == RESET_AS_HARD; // RULE17
			indConn <= connId; // RULE18
			if (openReq && state == S_IDLE) begin
				reqStatus <= ST_GOOD;
				reqConn <= connId + 1'b1; // RULE18
				connectedInd <= 1'b1; // RULE3
				indConn <= connId + 1'b1; // RULE18
			end else if (openReq) begin
				reqStatus <= ST_PORT_IN_USE; // RULE4
			end else if (reqValid && reqOp == OP_RECEIVE) begin
				reqStatus <= (state == S_IDLE) ? ST_NOT_OPEN : ST_GOOD; // RULE15
			end else if (reqValid) begin
				reqStatus <= (state == S_OPEN) ? ST_GOOD : ST_NOT_OPEN;
			end
			if (state == S_CLOSING && rxEmpty && !rcvActive &&
					sendLeft == '0 && !txValid) begin
				closedInd <= 1'b1; // RULE16
			end
		end
	end

	// ====================================================================
	// Send path
	// The length is trusted as the encoded count; the adapter does no
	// escaping of its own.
	// Ready is registered from the next count, so it drops right after
	// the last character. The network side is taken to sink at once: a
	// character offered while txReady is low and txValid is high would be lost.
	always_comb begin
		next_sendLeft = sendLeft;
		if (reqValid && reqOp == OP_SEND && state == S_OPEN &&
				sendLeft == '0)
			next_sendLeft = reqLength; // RULE10
		else if (sendValid && sendReady)
			next_sendLeft = sendLeft - 1'b1; // RULE13
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sendLeft <= '0;
		else
			sendLeft <= next_sendLeft;
	end

	assign txChars.valid = sendValid && sendReady; // RULE8
	assign txChars.data = sendData;
	assign txChars.last = sendLeft == LEN_W'(1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sendReady <= 1'b0;
		else
			sendReady <= next_sendLeft != '0; // RULE13
	end

	tx_framer #(.PAYLOAD(PAYLOAD)) u_tx (
		.clk(clk),
		.resetn(resetn),
		.chars(txChars),
		.dstIp(remoteIp), // RULE9
		.srcPort(srcPort),
		.txValid(txValid),
		.txData(txData),
		.txStart(txStart),
		.txEnd(txEnd),
		.txDstIp(txDstIp),
		.txSrcPort(txSrcPort),
		.txDstPort(txDstPort),
		.txReady(txReady)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			txPortSel <= '0;
		else
			txPortSel <= portSel; // RULE6
	end

	// ====================================================================
	// Receive path
	// Datagram filtering is decided on the first character and held.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			dgramOk <= 1'b0;
		else if (rxValid && rxStart)
			dgramOk <= rxDstPort == WELL_KNOWN_PORT && rxPortSel == portSel; // RULE7
	end

	// Characters are dropped once closing, and whenever the store is full.
	assign rxFill.valid = rxValid && state == S_OPEN && // RULE14
		(rxStart ? (rxDstPort == WELL_KNOWN_PORT && rxPortSel == portSel) :
		dgramOk); // RULE7 RULE12
	assign rxFill.data = rxData;
	assign rxFill.last = 1'b0;

	rx_buffer #(.DEPTH(DEPTH)) u_rx (
		.clk(clk),
		.resetn(resetn),
		.flush(state == S_IDLE),
		.fill(rxFill),
		.drain(rxDrain),
		.isEmpty(rxEmpty)
	);

	assign rxDrain.ready = rcvActive && rcvLeft != '0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rcvActive <= 1'b0;
			rcvLeft <= '0;
			rcvPlaced <= '0;
			rcvValid <= 1'b0;
			rcvData <= '0;
			receivedInd <= 1'b0;
			receivedCount <= '0;
		end else begin
			rcvValid <= rxDrain.valid && rxDrain.ready;
			rcvData <= rxDrain.data;
			receivedInd <= 1'b0;
			if (reqValid && reqOp == OP_RECEIVE && state != S_IDLE &&
					!rcvActive && reqLength != '0) begin
				rcvActive <= 1'b1; // RULE15
				rcvLeft <= reqLength; // RULE11
				rcvPlaced <= '0;
			end else if (rcvActive) begin
				if (rxDrain.valid && rxDrain.ready) begin
					rcvLeft <= rcvLeft - 1'b1; // RULE11
					rcvPlaced <= rcvPlaced + 1'b1;
				end
				// Ends when the count is met or the store runs dry after
				// at least one character.
				if ((rcvLeft == LEN_W'(1) && rxDrain.valid) ||
						(rxDrain.valid && rxDrain.last)) begin
					rcvActive <= 1'b0;
					receivedInd <= 1'b1; // RULE12
					receivedCount <= rcvPlaced + 1'b1; // RULE12
				end
			end
		end
	end
endmodule

//--- udp_adapter_chk.sv
`timescale 1ns/1ps
module udp_adapter_chk
	import udp_adapter_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Requests
	input wire logic reqValid,
	input wire op_t reqOp,
	input wire logic [LEN_W-1:0] reqLength,
	input wire logic reqDone,
	input wire logic [1:0] reqStatus,
	input wire logic [CONN_W-1:0] reqConn,
	// Indications and network
	input wire logic rcvValid,
	input wire logic connectedInd,
	input wire logic receivedInd,
	input wire logic [LEN_W-1:0] receivedCount,
	input wire logic closedInd,
	input wire logic [CONN_W-1:0] indConn,
	input wire logic txValid,
	input wire logic [15:0] txSrcPort,
	input wire logic [15:0] txDstPort
);
	logic [LEN_W-1:0] rxMax;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxMax <= '0;
		end else if (reqValid && reqOp == OP_RECEIVE) begin
			rxMax <= reqLength;
		end
	end
	// ====================================================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_done_follows_req: assert property (reqValid |=> reqDone)
		else $error("request not completed next cycle");
	a_done_has_cause: assert property (reqDone |-> $past(reqValid))
		else $error("completion without request");
	a_open_no_tx: assert property ((reqValid && !txValid
		&& (reqOp == OP_CONNECT || reqOp == OP_LISTEN)) |=> !txValid [*2])
		else $error("link traffic on open");
	a_conn_with_id: assert property (connectedInd |-> reqDone
		&& reqStatus == ST_GOOD && indConn == reqConn)
		else $error("connected indication mismatch");
	a_refused_quiet: assert property ((reqDone
		&& reqStatus == ST_PORT_IN_USE) |-> !connectedInd)
		else $error("refused open still connected");
	a_tx_dst_port: assert property (txValid |-> txDstPort == WELL_KNOWN_PORT)
		else $error("wrong destination port");
	a_tx_src_port: assert property (txValid |->
		txSrcPort[15:CONN_W] == SRC_PORT_BASE[15:CONN_W])
		else $error("wrong source port");
	a_rcv_bound: assert property (receivedInd |-> receivedCount <= rxMax)
		else $error("delivered above maximum");
	a_closed_idle: assert property (closedInd |-> !rcvValid && !receivedInd)
		else $error("closed while delivering");
	c_conn: cover property (connectedInd);
	c_refuse: cover property (reqDone && reqStatus == ST_PORT_IN_USE);
	c_recv: cover property (receivedInd);
	c_closed: cover property (closedInd);
endmodule
bind udp_link_service_adapter udp_adapter_chk chk (.clk(clk), .resetn(resetn),
	.reqValid(reqValid), .reqOp(reqOp), .reqLength(reqLength),
	.reqDone(reqDone), .reqStatus(reqStatus), .reqConn(reqConn),
	.rcvValid(rcvValid), .connectedInd(connectedInd),
	.receivedInd(receivedInd), .receivedCount(receivedCount),
	.closedInd(closedInd), .indConn(indConn), .txValid(txValid),
	.txSrcPort(txSrcPort), .txDstPort(txDstPort));

//--- net_peer.sv
`timescale 1ns/1ps
module net_peer
	import udp_adapter_pkg::*;
(
	// Clock
	input wire logic clk,
	// Adapter transmit side
	input wire logic txValid,
	output logic txReady,
	// Adapter receive side
	output logic rxValid,
	output logic [CHAR_W-1:0] rxData,
	output logic rxStart,
	output logic [15:0] rxDstPort,
	output logic [SEL_W-1:0] rxPortSel
);
	// The far host sinks at once; after a datagram the idle data and destination port lines carry inverted junk, while the port select holds.
	initial begin
		txReady = 1'b1;
		rxValid = 1'b0;
		rxData = 8'h00;
		rxStart = 1'b0;
		rxDstPort = 16'h0000;
		rxPortSel = 2'h0;
	end
	task automatic dgram(input logic [15:0] port, input int n,
		input logic [7:0] b);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			rxValid = 1'b1;
			rxStart = (i == 0);
			rxData = b + 8'(i);
			rxDstPort = port;
			rxPortSel = 2'h1;
		end
		@(posedge clk);
		#1;
		rxValid = 1'b0;
		rxStart = 1'b0;
		rxData = ~rxData;
		rxDstPort = ~port;
	endtask
endmodule

//--- udp_link_service_adapter_test.sv
`timescale 1ns/1ps
module udp_link_service_adapter_test;
	import udp_adapter_pkg::*;
	logic clk, resetn, reqValid, sendValid, resetInd, reqDone, rcvValid;
	logic connectedInd, receivedInd, closedInd, hardResetReq, sendReady;
	logic txValid, txStart, txEnd, txReady, rxValid, rxStart;
	op_t reqOp;
	logic [SEL_W-1:0] reqLocalPort, rxPortSel, txPortSel;
	logic [IP_W-1:0] reqRemoteIp, txDstIp;
	logic [LEN_W-1:0] reqLength, receivedCount;
	logic [1:0] reqStatus, rStatus;
	logic [CONN_W-1:0] reqConn, indConn, rConn, rIndConn;
	logic [CHAR_W-1:0] sendData, rcvData, txData, rxData;
	logic [15:0] txSrcPort, txDstPort, rxDstPort;
	logic rDone, rInd;
	int errors, checks;
	localparam int SPLIT = 4;
	udp_link_service_adapter #(.PAYLOAD(SPLIT)) uut (.clk(clk),
		.resetn(resetn),
		.reqValid(reqValid), .reqOp(reqOp), .reqLocalPort(reqLocalPort),
		.reqRemoteIp(reqRemoteIp), .reqLength(reqLength), .reqDone(reqDone),
		.reqStatus(reqStatus), .reqConn(reqConn), .sendValid(sendValid),
		.sendData(sendData), .sendReady(sendReady), .rcvValid(rcvValid),
		.rcvData(rcvData), .connectedInd(connectedInd),
		.receivedInd(receivedInd), .receivedCount(receivedCount),
		.closedInd(closedInd), .indConn(indConn), .resetInd(resetInd),
		.hardResetReq(hardResetReq), .txValid(txValid), .txData(txData),
		.txStart(txStart), .txEnd(txEnd), .txDstIp(txDstIp),
		.txSrcPort(txSrcPort), .txDstPort(txDstPort), .txPortSel(txPortSel),
		.txReady(txReady), .rxValid(rxValid), .rxData(rxData),
		.rxStart(rxStart), .rxDstPort(rxDstPort), .rxPortSel(rxPortSel));
	net_peer peer (.clk(clk), .txValid(txValid), .txReady(txReady),
		.rxValid(rxValid), .rxData(rxData), .rxStart(rxStart),
		.rxDstPort(rxDstPort), .rxPortSel(rxPortSel));
	// ====================================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, exp, input string msg);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic req(input op_t op, input logic [15:0] len);
		@(posedge clk);
		#1;
		reqValid = 1'b1;
		reqOp = op;
		reqLength = len;
		@(posedge clk);
		#1;
		reqValid = 1'b0;
		rDone = reqDone;
		rStatus = reqStatus;
		rConn = reqConn;
		rInd = connectedInd;
		rIndConn = indConn;
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Delivery is awaited under a bound; the store may end a chunk early.
	task automatic rcv(input logic [15:0] len, input int n,
		input logic [7:0] b, input logic [7:0] id);
		int got;
		logic seen;
		got = 0;
		seen = 1'b0;
		req(OP_RECEIVE, len);
		for (int i = 0; i < 60 && !seen; i++) begin
			if (rcvValid === 1'b1) begin
				check(rcvData, b + got, "data");
				got++;
			end
			if (receivedInd === 1'b1) begin
				seen = 1'b1;
				check(receivedCount, n, "count");
				check(indConn, id, "ind id");
			end
			@(posedge clk);
			#1;
		end
		check(got, n, "chars");
		check(seen, 1, "no received");
	endtask
	// ====================================================================
	// Scenarios
	task automatic t_connect();
		req(OP_CONNECT, 16'h0000);
		check(rDone, 1, "done");
		check(rStatus, ST_GOOD, "status");
		check(rInd, 1, "connected");
		check(rConn, 8'h01, "id");
		check(rIndConn, 8'h01, "ind id");
		repeat (8) begin
			@(posedge clk);
			#1;
			check(txValid, 0, "tx on open");
		end
		$display("test connect done");
	endtask
	task automatic t_refuse();
		req(OP_CONNECT, 16'h0000);
		check(rStatus, ST_PORT_IN_USE, "connect");
		check(rInd, 0, "connect ind");
		req(OP_LISTEN, 16'h0000);
		check(rStatus, ST_PORT_IN_USE, "listen");
		check(rInd, 0, "listen ind");
		$display("test refuse done");
	endtask
	// A six-character send is closed at once; all of it must still leave,
	// split into datagrams of at most SPLIT characters, before closed is raised.
	task automatic t_send();
		int n;
		logic took;
		n = 0;
		req(OP_SEND, 16'h0006);
		req(OP_CLOSE, 16'h0000);
		check(rStatus, ST_GOOD, "close in send");
		fork
			begin
				sendValid = 1'b1;
				sendData = 8'h40;
				for (int k = 0; k < 40 && sendValid; k++) begin
					took = sendReady;
					@(posedge clk);
					#1;
					if (took) begin
						sendData = sendData + 8'h01;
						if (sendData == 8'h46)
							sendValid = 1'b0;
					end
				end
			end
			begin
				for (int c = 0; c < 40 && n < 6; c++) begin
					@(posedge clk);
					#1;
					if (txValid === 1'b1) begin
						check(txData, 8'h40 + n, "tx data");
						check(txStart, n % SPLIT == 0, "start");
						check(txEnd, n % SPLIT == SPLIT - 1 ||
							n == 5, "end");
						check(txDstIp, 32'h0A000002, "ip");
						check(txDstPort, WELL_KNOWN_PORT, "dp");
						check(txSrcPort, SRC_PORT_BASE | 16'h0001,
							"sp");
						check(txPortSel, 2'h1, "sel");
						check(closedInd, 0, "closed in send");
						n++;
					end
				end
			end
		join
		check(n, 6, "tx chars");
		check(sendReady, 0, "ready after send");
		rInd = 1'b0;
		for (int i = 0; i < 20 && !rInd; i++) begin
			@(posedge clk);
			#1;
			rInd = closedInd;
		end
		check(rInd, 1, "closed after send");
		req(OP_CONNECT, 16'h0000);
		check(rStatus, ST_GOOD, "reconnect");
		check(rConn, 8'h02, "reconnect id");
		$display("test send done");
	endtask
	task automatic t_logout();
		@(posedge clk);
		#1;
		resetInd = 1'b1;
		@(posedge clk);
		#1;
		resetInd = 1'b0;
		check(hardResetReq, 0, "hard reset");
		req(OP_CONNECT, 16'h0000);
		check(rStatus, ST_GOOD, "after logout");
		check(rConn, 8'h04, "logout id");
		$display("test logout done");
	endtask
	task automatic t_receive();
		peer.dgram(16'h1050, 3, 8'h55);
		peer.dgram(16'h1049, 4, 8'hA0);
		rcv(16'h0003, 3, 8'hA0, 8'h02);
		rcv(16'h0008, 1, 8'hA3, 8'h02);
		$display("test receive done");
	endtask
	task automatic t_close();
		peer.dgram(16'h1049, 2, 8'h30);
		req(OP_CLOSE, 16'h0000);
		check(rStatus, ST_GOOD, "close");
		repeat (6) begin
			@(posedge clk);
			#1;
			check(closedInd, 0, "closed early");
		end
		rcv(16'h0008, 2, 8'h30, 8'h02);
		rInd = 1'b0;
		for (int i = 0; i < 40 && !rInd; i++) begin
			if (closedInd === 1'b1) begin
				rInd = 1'b1;
				check(indConn, 8'h02, "closed id");
			end
			@(posedge clk);
			#1;
		end
		check(rInd, 1, "no closed");
		req(OP_LISTEN, 16'h0000);
		check(rStatus, ST_GOOD, "reopen");
		check(rConn, 8'h03, "new id");
		$display("test close done");
	endtask
	// ====================================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		finish_test();
	end
	initial begin
		errors = 0;
		checks = 0;
		resetn = 1'b0;
		reqValid = 1'b0;
		reqOp = OP_CONNECT;
		reqLocalPort = 2'h1;
		reqRemoteIp = 32'h0A000002;
		reqLength = 16'h0000;
		sendValid = 1'b0;
		sendData = 8'h00;
		resetInd = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_connect();
		t_refuse();
		t_send();
		t_receive();
		t_close();
		t_logout();
		finish_test();
	end
endmodule
